//--- bench/video_source_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Far-side source: free raster with line, frame and field
module video_source_model #(
  parameter int TOT = 64, // Pixels per line
  parameter int LINES = 4 // Lines per frame
) (
  input wire logic sys_clk_i,
  input wire logic field_high_i, // Field level to present
  output logic hs_o,
  output logic vs_o,
  output logic fid_o
);
  int pix = 0;
  int line = 0;
  // Syncs rise at line start, active high
  always @(posedge sys_clk_i)
  begin
    pix <= (pix == TOT - 1) ? 0 : pix + 1;
    if (pix == TOT - 1)
      line <= (line == LINES - 1) ? 0 : line + 1;
    hs_o <= (pix < 4);
    vs_o <= (line == 0);
    fid_o <= field_high_i;
  end
endmodule
`default_nettype wire

//--- bench/video_sync_timing_generator_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module video_sync_timing_generator_tb_top;
  import video_timing_pkg::*;
  localparam int TOT = 64; // Short line keeps the run brief
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] mode = 4'h0;
  logic master = 1'b0;
  logic emb = 1'b0; // Embedded sync select
  logic fhi = 1'b1; // Source field level
  logic pass = 1'b0;
  logic p;
  logic [PIX_W-1:0] hid = 13'h0000;
  logic [15:0][LINE_W-1:0] bp = {{15{11'h000}}, 11'h7ff};
  logic [15:0][2:0] kd = '0;
  sync_out_cfg_t so = '{13'h0014, 13'h0003, 11'h001, 11'h001, 11'h000,
    11'h000, 1'b1, 1'b1};
  hspec_t spec = '{13'h0008, 13'h0006, 13'h000a, 13'h0014, 13'h0010,
    13'h000c};
  amp_t amp = '{10'h040, 10'h3c0, 10'h200, 10'h080, 10'h380, 10'h1f0};
  pixel_t vin = {3{10'h155}};
  pixel_t vout;
  logic shs, svs, sfid, hs_o, hs_oe, vs_o, vs_oe, dhs, dvs, fid_o, run;
  int fails = 0, check_count = 0, lo, hi, vd, cl, hn, mp, n, vn, fn, pn;
  // Case table: mode, line kind, pass enable, expected counts
  int md[6] = '{2, 2, 2, 3, 3, 0};
  int kl[6] = '{0, 1, 1, 0, 1, 0};
  int pe[6] = '{0, 0, 1, 0, 0, 0};
  int elo[6] = '{4, 4, 4, 8, 8, 0};
  int ehi[6] = '{6, 6, 6, 0, 0, 0};
  int evd[6] = '{42, 0, 42, 32, 0, 64};
  // Low pixels per double line: 4 tip and 3 broad per half
  int edl[4] = '{8, 14, 11, 11};
  // Pin level: device wins while it drives
  wire logic hs_w = hs_oe ? hs_o : shs;
  wire logic vs_w = vs_oe ? vs_o : svs;
  always #50 sys_clk = ~sys_clk;
  video_source_model #(.TOT(TOT), .LINES(4)) src (.sys_clk_i(sys_clk),
    .field_high_i(fhi), .hs_o(shs), .vs_o(svs), .fid_o(sfid));
  video_sync_timing_generator dut (.sys_clk_i(sys_clk), .srst_i(srst),
    .timing_mode_field_i(mode), .master_mode_i(master),
    .embedded_timing_i(emb), .hsync_pin_i(hs_w), .vsync_pin_i(vs_w),
    .field_id_i(sfid), .embed_hsync_i(shs), .embed_vsync_i(svs),
    .embed_field_i(sfid), .pixels_per_line_i(13'(TOT)),
    .first_field_lines_i(11'h002), .frame_lines_i(11'h004),
    .horizontal_input_delay_i(hid), .vertical_input_delay_i(11'h000),
    .horizontal_timing_parameters_i(spec), .amp_i(amp),
    .blanking_line_pass_enable_i(pass), .line_number_entry_i(bp),
    .line_kind_entry_i(kd), .sync_out_cfg_i(so), .video_i(vin),
    .video_o(vout), .dedicated_hsync_output_o(dhs),
    .dedicated_vsync_output_o(dvs), .hsync_pin_o(hs_o),
    .hsync_pin_oe_o(hs_oe), .vsync_pin_o(vs_o), .vsync_pin_oe_o(vs_oe),
    .field_id_o(fid_o), .running_o(run));
  // ==========================================
  // Shared helpers
  task automatic results();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A spent wait counts as a mismatch and ends the run
  task automatic bound(input int c);
    if (c >= 600)
    begin
      fails++;
      results();
    end
  endtask
  // Settle two lines, then count levels over exactly one line
  task automatic win();
    lo = 0; hi = 0; vd = 0; cl = 0; hn = 0; mp = 0;
    repeat (2 * TOT) @(negedge sys_clk);
    repeat (TOT)
    begin
      @(negedge sys_clk);
      lo += int'(vout[0] === amp.y_low);
      hi += int'(vout[0] === amp.y_high);
      vd += int'(vout[0] === vin[0]);
      cl += int'(vout[1] === amp.c_low);
      hn += int'(dhs === 1'b1);
      mp += int'(hs_o === 1'b1);
    end
  endtask
  // Count vertical levels over exactly one four-line frame
  task automatic frm();
    vn = 0; fn = 0; pn = 0;
    repeat (4 * TOT)
    begin
      @(negedge sys_clk);
      vn += int'(dvs === 1'b1);
      fn += int'(fid_o === 1'b1);
      pn += int'(vs_o === 1'b1);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_start();
    chk(16'(run), 16'h0000);
    repeat (8 * TOT) @(negedge sys_clk);
    chk(16'(run), 16'h0000);
    @(posedge sys_clk) fhi <= 1'b0;
    for (n = 0; n < 600 && run !== 1'b1; n++)
      @(negedge sys_clk);
    bound(n);
    chk(16'(run), 16'h0001);
    $display("test start done");
  endtask
  // Pin syncs, then embedded syncs with a shifted start value
  task automatic t_dedicated();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      hid <= 13'(5 * i);
      emb <= i[0];
      repeat (2 * TOT) @(posedge sys_clk);
      for (n = 0; n < 600; n++)
      begin
        p = shs;
        @(negedge sys_clk);
        if (p === 1'b0 && shs === 1'b1)
          break;
      end
      bound(n);
      for (n = 1; n < 600 && dhs !== 1'b1; n++)
        @(negedge sys_clk);
      bound(n);
      chk(16'(n), 16'(23 - 5 * i));
      win();
      chk(16'(hn), 16'h0003);
    end
    @(posedge sys_clk) so.hpol <= 1'b0;
    win();
    chk(16'(hn), 16'(TOT - 3));
    @(posedge sys_clk) so.hpol <= 1'b1;
    frm();
    chk(16'(vn), 16'h0040);
    chk(16'(fn), 16'h0080);
    $display("test dedicated done");
  endtask
  task automatic t_composite();
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk);
      mode <= 4'(md[i]);
      kd[0] <= 3'(kl[i]);
      pass <= pe[i][0];
      win();
      chk(16'(lo), 16'(elo[i]));
      chk(16'(hi), 16'(ehi[i]));
      chk(16'(vd), 16'(evd[i]));
      chk(16'(cl), 16'(elo[i]));
      chk(16'(hn), 16'h0003);
    end
    $display("test composite done");
  endtask
  // Short syncs let all eleven states fit in a 32-pixel half line
  task automatic t_double();
    @(posedge sys_clk);
    spec <= '{13'h0002, 13'h0006, 13'h0006, 13'h000a, 13'h0010,
      13'h000f};
    mode <= MODE_HD_GENERIC;
    for (int i = 2; i < 6; i++)
    begin
      @(posedge sys_clk) kd[0] <= 3'(i);
      win();
      chk(16'(lo), 16'(edl[i - 2]));
      chk(16'(hi), 16'h0004);
      chk(16'(vd), 16'h0000);
    end
    // Source frame keeps the line counter below 6: broad lines only
    @(posedge sys_clk) mode <= MODE_HD_1125I;
    win();
    chk(16'(lo), 16'h000e);
    @(posedge sys_clk);
    spec <= '{13'h0008, 13'h0006, 13'h000a, 13'h0014, 13'h0010,
      13'h000c};
    $display("test double done");
  endtask
  // Master is refused outside PC timing, granted inside it
  task automatic t_master();
    @(posedge sys_clk);
    master <= 1'b1;
    mode <= MODE_HD_GENERIC;
    win();
    chk(16'(hs_oe), 16'h0000);
    @(posedge sys_clk) mode <= MODE_PC;
    win();
    chk(16'(mp), 16'h0008);
    chk(16'({hs_oe, vs_oe, fid_o}), 16'h0006);
    frm();
    chk(16'(pn), 16'h0040);
    chk(16'(fn), 16'h0000);
    $display("test master done");
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    t_start();
    t_dedicated();
    t_composite();
    t_double();
    t_master();
    results();
  end
endmodule
`default_nettype wire

//--- verilog/line_kind_lookup.sv
`timescale 1ns/1ns
`default_nettype none
module line_kind_lookup #(
  parameter int N_BP = 16
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic preset_i,
  input wire logic [video_timing_pkg::LINE_W-1:0] line_i,
  input wire logic [N_BP-1:0][video_timing_pkg::LINE_W-1:0] bp_i,
  input wire logic [N_BP-1:0][2:0] kind_i,
  output video_timing_pkg::line_kind_t line_kind_o
);
  import video_timing_pkg::*;
  // ==========================================
  // State
  typedef struct packed {
    line_kind_t kind; // Kind of the current line
  } lk_state_t;
  lk_state_t lk_ff;
  lk_state_t nxt_lk;

  // Lowest entry whose line number lies beyond the line wins
  always_comb
  begin
    nxt_lk.kind = KIND_RST;
    if (preset_i)
    begin
      for (int i = PRE_N - 1; i >= 0; i--)
        if (PRE_BP[i] > line_i)
          nxt_lk.kind = PRE_KIND[i];
    end
    else
    begin
      for (int i = N_BP - 1; i >= 0; i--)
        if (bp_i[i] > line_i)
          nxt_lk.kind = line_kind_t'(kind_i[i]);
    end
  end

  // Register the looked up kind
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      lk_ff <= '{kind: KIND_RST};
    else
      lk_ff <= nxt_lk;

  assign line_kind_o = lk_ff.kind;
endmodule
`default_nettype wire

//--- verilog/sync_output_gen.sv
`timescale 1ns/1ns
`default_nettype none
module sync_output_gen (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [video_timing_pkg::PIX_W-1:0] pix_i,
  input wire logic [video_timing_pkg::LINE_W-1:0] line_i,
  input wire video_timing_pkg::sync_out_cfg_t cfg_i,
  output logic hsync_o,
  output logic vsync_o
);
  import video_timing_pkg::*;
  // ==========================================
  // State
  typedef struct packed {
    logic hs; // Dedicated hsync level
    logic vs; // Dedicated vsync level
  } so_state_t;
  so_state_t so_ff;
  so_state_t nxt_so;
  logic [PIX_W-1:0] hoff; // Pixel offset into the hsync window
  logic [LINE_W-1:0] voff1, voff2; // Line offsets into vsync windows

  // Offsets wrap at the counter width, so a window does not straddle the line or frame end
  assign hoff = PIX_W'(pix_i - cfg_i.hdly);
  assign voff1 = LINE_W'(line_i - cfg_i.vdly1);
  assign voff2 = LINE_W'(line_i - cfg_i.vdly2);

  // Windows come from the counters only, never from composite sync
  always_comb
  begin
    nxt_so.hs = (hoff < cfg_i.hlen) ~^ cfg_i.hpol;
    nxt_so.vs = ((voff1 < cfg_i.vlen1) || (voff2 < cfg_i.vlen2))
      ~^ cfg_i.vpol;
  end

  // Register outputs to line up with the DAC data
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      so_ff <= '0;
    else
      so_ff <= nxt_so;

  assign hsync_o = so_ff.hs;
  assign vsync_o = so_ff.vs;

  AST_HS_WINDOW:
  assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (pix_i == cfg_i.hdly && cfg_i.hlen != '0) |=> hsync_o == $past(cfg_i.hpol))
    else $error("hsync not active at its programmed position");
  AST_VS_OUTSIDE:
  assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (voff1 >= cfg_i.vlen1 && voff2 >= cfg_i.vlen2)
    |=> vsync_o == !$past(cfg_i.vpol))
    else $error("vsync active outside its windows");
endmodule
`default_nettype wire

//--- verilog/video_sync_timing_generator.sv
`timescale 1ns/1ns
`default_nettype none
module video_sync_timing_generator #(
  parameter int N_BP = 16
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] timing_mode_field_i,
  input wire logic master_mode_i,
  input wire logic embedded_timing_i,
  input wire logic hsync_pin_i,
  input wire logic vsync_pin_i,
  input wire logic field_id_i,
  input wire logic embed_hsync_i,
  input wire logic embed_vsync_i,
  input wire logic embed_field_i,
  input wire logic [video_timing_pkg::PIX_W-1:0] pixels_per_line_i,
  input wire logic [video_timing_pkg::LINE_W-1:0] first_field_lines_i,
  input wire logic [video_timing_pkg::LINE_W-1:0] frame_lines_i,
  input wire logic [video_timing_pkg::PIX_W-1:0] horizontal_input_delay_i,
  input wire logic [video_timing_pkg::LINE_W-1:0] vertical_input_delay_i,
  input wire video_timing_pkg::hspec_t horizontal_timing_parameters_i,
  input wire video_timing_pkg::amp_t amp_i,
  input wire logic blanking_line_pass_enable_i,
  input wire logic [N_BP-1:0][video_timing_pkg::LINE_W-1:0]
    line_number_entry_i,
  input wire logic [N_BP-1:0][2:0] line_kind_entry_i,
  input wire video_timing_pkg::sync_out_cfg_t sync_out_cfg_i,
  input wire video_timing_pkg::pixel_t video_i,
  output video_timing_pkg::pixel_t video_o,
  output logic dedicated_hsync_output_o,
  output logic dedicated_vsync_output_o,
  output logic hsync_pin_o,
  output logic hsync_pin_oe_o,
  output logic vsync_pin_o,
  output logic vsync_pin_oe_o,
  output logic field_id_o,
  output logic running_o
);
  import video_timing_pkg::*;
  // ==========================================
  // State
  typedef struct packed {
    run_state_t st; // Startup state
    logic [PIX_W-1:0] pix; // Pixel counter
    logic [LINE_W-1:0] line; // Line counter, first line is 1
    logic hs_d; // Previous hsync source level
    logic vs_d; // Previous vsync source level
    logic hpin; // Driven hsync pin level
    logic vpin; // Driven vsync pin level
    logic pin_oe; // Sync pins driven
    logic fid; // Field ID output
    pixel_t video; // DAC data
  } tg_state_t;
  tg_state_t tg_ff;
  tg_state_t nxt_tg;
  hspec_t hs; // Short alias of the timing parameters
  logic pc_mode, sd_mode, preset; // Decoded timing mode
  logic master_act; // Master mode in effect
  logic hs_src, vs_src, fid_src; // Selected slave sync sources
  logic hs_rise, vs_rise; // Sync start events
  logic [LINE_W-1:0] frame_n, field_n; // Effective frame/field sizes
  line_kind_t cur_kind; // Kind of the current line
  level_t lvl; // Level selected for this pixel
  pixel_t chan_nxt; // Per channel generated data

  // ==========================================
  // Mode decode and sync source selection
  assign hs = horizontal_timing_parameters_i;
  assign pc_mode = (timing_mode_field_i == MODE_PC);
  assign sd_mode = (timing_mode_field_i == MODE_SD_GENERIC);
  assign preset = (timing_mode_field_i == MODE_HD_1125I);
  // Master is refused outside the progressive PC mode
  assign master_act = master_mode_i && pc_mode;
  // Slave syncs come from embedded codes or dedicated pins
  assign hs_src = embedded_timing_i ? embed_hsync_i : hsync_pin_i;
  assign vs_src = embedded_timing_i ? embed_vsync_i : vsync_pin_i;
  assign fid_src = embedded_timing_i ? embed_field_i : field_id_i;
  assign hs_rise = hs_src && !tg_ff.hs_d;
  assign vs_rise = vs_src && !tg_ff.vs_d;
  // Preset overrides the programmed sizes
  assign frame_n = preset ? PRE_FRAME : frame_lines_i;
  assign field_n = preset ? PRE_FIELD : first_field_lines_i;

  // ==========================================
  // Line kind table
  line_kind_lookup #(
    .N_BP(N_BP)
  ) u_lookup (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .preset_i(preset),
    .line_i(tg_ff.line),
    .bp_i(line_number_entry_i),
    .kind_i(line_kind_entry_i),
    .line_kind_o(cur_kind)
  );

  // ==========================================
  // Line waveforms
  // HD single line: nine states, 2T/4T/4T/2T fixed ones
  function automatic level_t hd_full_level(input logic [PIX_W-1:0] p,
    input logic [PIX_W-1:0] tot, input hspec_t s, input logic pass);
    level_t l;
    l = LV_MID_LO; // State 9, last 2T rising to blank
    if (p < T2)
      l = LV_MID_HI; // State 1, 2T blank to positive
    else if (p < s.c - T2)
      l = LV_HIGH; // State 2
    else if (p < s.c + T2)
      l = LV_MID_HI; // State 3, 4T back to blank
    else if (p < s.e)
      l = LV_BLANK; // State 4
    else if (p < tot - s.b)
      l = pass ? LV_VIDEO : LV_BLANK; // State 5
    else if (p < tot - s.a - T2)
      l = LV_BLANK; // State 6
    else if (p < tot - s.a + T2)
      l = LV_MID_LO; // State 7, 4T down to negative
    else if (p < tot - T2)
      l = LV_LOW; // State 8
    return l;
  endfunction

  // HD double line: eleven states repeated each half line
  function automatic level_t hd_double_level(input logic [PIX_W-1:0] p,
    input logic [PIX_W-1:0] tot, input hspec_t s, input logic br1,
    input logic br2);
    level_t l;
    logic [PIX_W-1:0] h, hp;
    logic br;
    h = tot >> 1;
    hp = (p >= h) ? PIX_W'(p - h) : p;
    br = (p >= h) ? br2 : br1;
    l = LV_MID_LO; // State 11, 2T
    if (hp < T2)
      l = LV_MID_HI; // State 1, 2T
    else if (hp < s.c - T2)
      l = LV_HIGH; // State 2
    else if (hp < s.c + T2)
      l = LV_MID_HI; // State 3, 4T
    else if (hp < s.d)
      l = LV_BLANK; // State 4
    else if (hp < s.d + T4)
      l = br ? LV_MID_LO : LV_BLANK; // State 5, 4T
    else if (hp < h - s.k)
      l = br ? LV_LOW : LV_BLANK; // State 6, broad pulse
    else if (hp < h - s.k + T4)
      l = br ? LV_MID_LO : LV_BLANK; // State 7, 4T
    else if (hp < h - s.a - T8)
      l = LV_BLANK; // State 8
    else if (hp < h - s.a - T4)
      l = LV_MID_LO; // State 9, 4T
    else if (hp < h - T2)
      l = LV_LOW; // State 10
    return l;
  endfunction

  // SD line: bi-level negative sync with 2T edges
  function automatic level_t sd_level(input logic [PIX_W-1:0] p,
    input logic [PIX_W-1:0] tot, input hspec_t s, input logic pass);
    level_t l;
    l = LV_BLANK;
    if (p < T1 || p >= tot - T1)
      l = LV_MID_LO; // 2T falling edge, 1T each side of 0H
    else if (p < s.a + T1)
      l = LV_LOW;
    else if (p < s.a + T3)
      l = LV_MID_LO; // 2T rising edge
    else if (p >= s.d && p < tot - s.k)
      l = pass ? LV_VIDEO : LV_BLANK;
    return l;
  endfunction

  // Level for this pixel; PC mode and startup pass input data
  always_comb
  begin
    lvl = LV_VIDEO;
    if (tg_ff.st == ST_RUN && !pc_mode)
    begin
      if (sd_mode)
        lvl = sd_level(tg_ff.pix, pixels_per_line_i, hs,
          cur_kind == LK_ACTIVE || (cur_kind == LK_FULL_TRI &&
          blanking_line_pass_enable_i));
      else if (cur_kind == LK_ACTIVE || cur_kind == LK_FULL_TRI)
        lvl = hd_full_level(tg_ff.pix, pixels_per_line_i, hs,
          cur_kind == LK_ACTIVE ||
          blanking_line_pass_enable_i);
      else
        lvl = hd_double_level(tg_ff.pix, pixels_per_line_i, hs,
          cur_kind == LK_DOUBLE_BROAD || cur_kind == LK_BROAD_TRI,
          cur_kind == LK_DOUBLE_BROAD ||
          cur_kind == LK_TRI_BROAD);
    end
  end

  // ==========================================
  // Output data selector, one lane per channel
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    logic [DATA_W-1:0] lo, hi, bl; // Amplitudes of this channel
    logic [DATA_W:0] sum_lo, sum_hi; // Sums for transition midpoints
    // Luma takes its own amplitudes, chroma share a set
    assign lo = (ch == 0) ? amp_i.y_low : amp_i.c_low;
    assign hi = (ch == 0) ? amp_i.y_high : amp_i.c_high;
    assign bl = (ch == 0) ? amp_i.y_blank : amp_i.c_blank;
    assign sum_lo = {1'b0, bl} + {1'b0, lo};
    assign sum_hi = {1'b0, bl} + {1'b0, hi};
    always_comb
    begin
      case (lvl)
        LV_LOW: chan_nxt[ch] = lo;
        LV_HIGH: chan_nxt[ch] = hi;
        LV_MID_LO: chan_nxt[ch] = sum_lo[DATA_W:1];
        LV_MID_HI: chan_nxt[ch] = sum_hi[DATA_W:1];
        LV_VIDEO: chan_nxt[ch] = video_i[ch];
        default: chan_nxt[ch] = bl;
      endcase
    end
  end

  // ==========================================
  // Counters, startup and master pins
  always_comb
  begin
    nxt_tg = tg_ff;
    nxt_tg.hs_d = hs_src;
    nxt_tg.vs_d = vs_src;
    // Free count with wrap at line and frame ends
    if (tg_ff.pix >= pixels_per_line_i - T1)
    begin
      nxt_tg.pix = PIX_RST;
      if (tg_ff.line >= frame_n)
        nxt_tg.line = LINE_FIRST;
      else
        nxt_tg.line = LINE_W'(tg_ff.line + LINE_FIRST);
    end
    else
      nxt_tg.pix = PIX_W'(tg_ff.pix + T1);
    // Slave: syncs load the delayed startup values
    if (!master_act)
    begin
      if (hs_rise)
        nxt_tg.pix = horizontal_input_delay_i;
      if (vs_rise)
        nxt_tg.line = LINE_W'(LINE_FIRST + vertical_input_delay_i);
    end
    // Start on field low at vsync start, or at once as master
    case (tg_ff.st)
      ST_WAIT_FIELD:
        if (master_act || (vs_rise && !fid_src))
          nxt_tg.st = ST_RUN;
      ST_RUN:
        nxt_tg.st = ST_RUN;
      default:
        nxt_tg.st = ST_WAIT_FIELD;
    endcase
    // Master drives the sync pins from its own counters
    nxt_tg.pin_oe = master_act;
    nxt_tg.hpin = master_act && (nxt_tg.pix < hs.a);
    nxt_tg.vpin = master_act && (nxt_tg.line == LINE_FIRST);
    // Field ID only as slave: second field past field_n (first_field_lines, or PRE_FIELD in the preset)
    nxt_tg.fid = !master_act && (nxt_tg.line > field_n);
    nxt_tg.video = chan_nxt;
  end

  // Register all state
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      tg_ff <= '{st: ST_WAIT_FIELD, pix: PIX_RST, line: LINE_FIRST,
        default: '0};
    else
      tg_ff <= nxt_tg;

  // ==========================================
  // Dedicated sync outputs, downstream of the counters
  sync_output_gen u_sync_out (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pix_i(tg_ff.pix),
    .line_i(tg_ff.line),
    .cfg_i(sync_out_cfg_i),
    .hsync_o(dedicated_hsync_output_o),
    .vsync_o(dedicated_vsync_output_o)
  );

  assign video_o = tg_ff.video;
  assign hsync_pin_o = tg_ff.hpin;
  assign vsync_pin_o = tg_ff.vpin;
  assign hsync_pin_oe_o = tg_ff.pin_oe;
  assign vsync_pin_oe_o = tg_ff.pin_oe;
  assign field_id_o = tg_ff.fid;
  assign running_o = tg_ff.st[1]; // One-hot run bit, straight from its flop

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_first_field;
    !master_act && tg_ff.st == ST_WAIT_FIELD && vs_rise && !fid_src;
  endsequence
  sequence s_hd_run;
    tg_ff.st == ST_RUN && !pc_mode && !sd_mode;
  endsequence

  AST_PC_PASS:
  assert property (pc_mode |=> video_o == $past(video_i))
    else $error("PC mode does not pass input data");
  AST_START:
  assert property (s_first_field |=> running_o ##1 running_o)
    else $error("generator did not start on first field");
  AST_NO_START:
  assert property ((tg_ff.st == ST_WAIT_FIELD && !master_act && !vs_rise)
    |=> !running_o)
    else $error("generator started without a vsync");
  AST_HS_LOAD:
  assert property ((!master_act && hs_rise)
    |=> tg_ff.pix == $past(horizontal_input_delay_i))
    else $error("pixel counter not loaded with input delay");
  AST_VS_LOAD:
  assert property ((!master_act && vs_rise) |=>
    tg_ff.line == LINE_W'(LINE_FIRST + $past(vertical_input_delay_i)))
    else $error("line counter not loaded with input delay");
  AST_PIX_WRAP:
  assert property ((tg_ff.pix >= pixels_per_line_i - T1 && !hs_rise)
    |=> tg_ff.pix == PIX_RST)
    else $error("pixel counter did not wrap");
  AST_MASTER_PINS:
  assert property ((master_act && tg_ff.st == ST_RUN)
    |=> hsync_pin_oe_o && vsync_pin_oe_o && !field_id_o)
    else $error("master mode does not drive sync pins");
  AST_NO_MASTER:
  assert property (!pc_mode |=> !hsync_pin_oe_o && !vsync_pin_oe_o)
    else $error("sync pins driven outside PC mode");
  AST_HD_TIP:
  assert property ((s_hd_run and (cur_kind == LK_ACTIVE && hs.a > T4 &&
    tg_ff.pix == pixels_per_line_i - T3)) |=> video_o[0] == amp_i.y_low)
    else $error("HD negative sync tip missing");
  AST_NO_PASS:
  assert property ((s_hd_run and (cur_kind == LK_FULL_TRI &&
    !blanking_line_pass_enable_i && tg_ff.pix >= hs.e &&
    tg_ff.pix < pixels_per_line_i - hs.b)) |=> video_o[0] == amp_i.y_blank)
    else $error("full tri-level line passed video");
  AST_SD_SYNC:
  assert property ((tg_ff.st == ST_RUN && sd_mode && hs.a > T2 &&
    tg_ff.pix == T1) |=> video_o[1] == amp_i.c_low)
    else $error("SD line does not start with negative sync");
endmodule
`default_nettype wire

//--- verilog/video_timing_pkg.sv
`default_nettype none
package video_timing_pkg;
  // ==========================================
  // Widths
  localparam int PIX_W = 13; // Pixel counter width
  localparam int LINE_W = 11; // Line counter width
  localparam int DATA_W = 10; // Per channel sample width
  localparam int NUM_CH = 3; // Luma/green plus two chroma
  // ==========================================
  // Timing mode field codes
  localparam logic [3:0] MODE_PC = 4'h0; // Dedicated syncs only
  localparam logic [3:0] MODE_HD_1125I = 4'h1; // Interlaced HD preset
  localparam logic [3:0] MODE_HD_GENERIC = 4'h2; // HD, user table
  localparam logic [3:0] MODE_SD_GENERIC = 4'h3; // SD, user table
  // ==========================================
  // Fixed transition lengths, in pixel clocks
  localparam logic [PIX_W-1:0] T1 = 13'h0001;
  localparam logic [PIX_W-1:0] T2 = 13'h0002;
  localparam logic [PIX_W-1:0] T3 = 13'h0003;
  localparam logic [PIX_W-1:0] T4 = 13'h0004;
  localparam logic [PIX_W-1:0] T8 = 13'h0008;
  // ==========================================
  // Reset and startup values
  localparam logic [PIX_W-1:0] PIX_RST = 13'h0000;
  localparam logic [LINE_W-1:0] LINE_FIRST = 11'h001;
  // ==========================================
  // Interlaced HD preset sizes and table
  localparam logic [LINE_W-1:0] PRE_FRAME = 11'h465; // 1125 lines
  localparam logic [LINE_W-1:0] PRE_FIELD = 11'h233; // 563 lines
  localparam int PRE_N = 11;
  typedef enum logic [2:0] {
    LK_ACTIVE = 3'h0, // Active video line
    LK_FULL_TRI = 3'h1, // full_tri_level_line
    LK_DOUBLE_TRI = 3'h2, // double_tri_level_line
    LK_DOUBLE_BROAD = 3'h3, // double_broad_pulse_line
    LK_TRI_BROAD = 3'h4, // Normal half, then broad half
    LK_BROAD_TRI = 3'h5 // Broad half, then normal half
  } line_kind_t;
  localparam line_kind_t KIND_RST = LK_FULL_TRI;
  localparam logic [LINE_W-1:0] PRE_BP [PRE_N] = '{11'h006, 11'h007,
    11'h015, 11'h231, 11'h233, 11'h234, 11'h238, 11'h239, 11'h248,
    11'h464, 11'h466};
  localparam line_kind_t PRE_KIND [PRE_N] = '{LK_DOUBLE_BROAD,
    LK_DOUBLE_TRI, LK_FULL_TRI, LK_ACTIVE, LK_FULL_TRI, LK_TRI_BROAD,
    LK_DOUBLE_BROAD, LK_BROAD_TRI, LK_FULL_TRI, LK_ACTIVE, LK_FULL_TRI};
  // ==========================================
  // Startup state and output level codes
  typedef enum logic [1:0] {
    ST_WAIT_FIELD = 2'b01, // Waiting for a first field
    ST_RUN = 2'b10 // Generator running
  } run_state_t;
  typedef enum logic [2:0] {
    LV_BLANK, LV_LOW, LV_HIGH, LV_MID_LO, LV_MID_HI, LV_VIDEO
  } level_t;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic [PIX_W-1:0] a, b, c, d, e, k; // Horizontal timing parameters
  } hspec_t;
  typedef struct packed {
    logic [DATA_W-1:0] y_low, y_high, y_blank; // Luma amplitudes
    logic [DATA_W-1:0] c_low, c_high, c_blank; // Chroma amplitudes
  } amp_t;
  typedef struct packed {
    logic [PIX_W-1:0] hdly, hlen; // Dedicated hsync position, width
    logic [LINE_W-1:0] vdly1, vlen1, vdly2, vlen2; // Two vsync windows
    logic hpol, vpol; // 1 = active high
  } sync_out_cfg_t;
  typedef logic [NUM_CH-1:0][DATA_W-1:0] pixel_t;
endpackage
`default_nettype wire
